// [adc_core_calibration_sequencer_tb_top.sv]
`timescale 1ns/100ps
`include "cal_seq_map.svh"
module adc_core_calibration_sequencer_tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic fire = 1'b0;
  logic [31:0] avs_readdata, rd, r;
  logic avs_waitrequest, irq, cal_trigger_pin;
  logic [11:0] sample_a, sample_b, sample_c, out_data_a, out_data_b;
  logic [1:0] core_input_sel;
  logic [2:0] bank_cal_active;
  logic [5:0] bank_phase;
  logic [31:0] trim_def[4] = '{`TRIM_OFFSET_DEF, `TRIM_GAIN_DEF,
    `TRIM_TIMING_DEF, `TRIM_TERM_DEF};
  logic [31:0] ctrl_mode[3] = '{32'h02, 32'h0a, 32'h1a};
  logic [31:0] sel_exp[3] = '{32'h1, 32'h0, 32'h3};
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int spare_q[$];
  always #2 clock = ~clock;

  cal_sequencer #(.FG_CYCLES(8), .BG_CYCLES(8)) DUT (
    .clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .cal_trigger_pin, .sample_a,
    .sample_b, .sample_c, .out_data_a, .out_data_b, .core_input_sel,
    .bank_cal_active, .bank_phase, .irq);
  host_side_model host (.clock, .fire, .cal_trigger_pin, .sample_a,
    .sample_b, .sample_c);

  task end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until the answering edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Poll a register until a bit shows, bounded
  task wait_bit(input logic [3:0] a, input int b);
    rd = 32'h0;
    for (int i = 0; i < 60 && rd[b] !== 1'b1; i++) bus(1'b0, a, 32'h0);
    chk(rd[b], 32'h1);
  endtask

  // Both outputs go to mid-code, then the done event follows
  task mute_check;
    for (int i = 0; i < 30 && out_data_a !== 12'h000; i++) @(posedge clock);
    chk(out_data_a, 32'h0);
    chk(out_data_b, 32'h0);
    chk(bank_cal_active, 32'h3);
    wait_bit(`REG_IRQ_STATUS, `IRQ_FOREGROUND_CAL_DONE);
  endtask

  // Cycle ceiling: a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      end_sim;
    end
  end

  initial begin
    int zeros;
    void'($urandom(32'h3088e36a));
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk(core_input_sel, 32'h1);
    chk(out_data_a, 32'h0);
    wait_bit(`REG_STATUS, `STAT_FOREGROUND_CAL_DONE);
    rd_chk(`REG_CTRL, `CTRL_RESET);
    for (int i = 0; i < 4; i++) begin
      rd_chk(4'(`REG_TRIM_BASE + i), trim_def[i]);
      r = {16'h0, 16'($urandom)};
      bus(1'b1, 4'(`REG_TRIM_BASE + i), r);
      rd_chk(4'(`REG_TRIM_BASE + i), r);
    end
    // Unmapped words ignore writes and read zero
    for (int i = 8; i < 16; i++) begin
      bus(1'b1, 4'(i), $urandom);
      rd_chk(4'(i), 32'h0);
    end
    bus(1'b1, `REG_IRQ_MASK, 32'h3);
    repeat (3) @(posedge clock);
    chk(irq, 32'h1);
    rd_chk(`REG_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge clock);
    chk(irq, 32'h0);
    rd_chk(`REG_IRQ_STATUS, 32'h0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `REG_CTRL, ctrl_mode[i]);
      repeat (3) @(posedge clock);
      chk(core_input_sel, sel_exp[i]);
    end
    // Pin trigger, then software trigger
    bus(1'b1, `REG_CTRL, 32'h2);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    mute_check;
    bus(1'b1, `REG_CTRL, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h4);
    mute_check;
    // Background run: output A never muted, spare rotates C, A, B
    bus(1'b1, `REG_CTRL, 32'h5);
    zeros = 0;
    repeat (40) begin
      @(posedge clock);
      if (out_data_a === 12'h000) zeros++;
    end
    chk(zeros, 32'h0);
    for (int i = 0; i < 300 && spare_q.size() < 4; i++) begin
      bus(1'b0, `REG_STATUS, 32'h0);
      if (spare_q.size() == 0 || spare_q[$] != rd[5:4])
        spare_q.push_back(rd[5:4]);
    end
    chk(spare_q.size(), 32'h4);
    for (int i = 1; i < spare_q.size(); i++)
      chk(spare_q[i], (spare_q[i - 1] + 1) % 3);
    chk(irq, 32'h1);
    rd_chk(`REG_IRQ_STATUS, 32'h2);
    end_sim;
  end
endmodule

// [cal_seq_map.svh]
`ifndef CAL_SEQ_MAP_SVH
`define CAL_SEQ_MAP_SVH

// Register word offsets (byte address = word index * 4)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_IRQ_STATUS 4'h2
`define REG_IRQ_MASK 4'h3
`define REG_TRIM_BASE 4'h4

// Control register fields
`define CTRL_BG_EN 0
`define CTRL_SRC_SEL 1
`define CTRL_SW_TRIG 2
`define CTRL_SINGLE 3
`define CTRL_IN_SEL 4
`define CTRL_FG_OS 5
`define CTRL_BG_OS 6

// Status fields
`define STAT_FOREGROUND_CAL_DONE 0
`define STAT_BUSY 1
`define STAT_OFFLINE_A 2
`define STAT_OFFLINE_B 3
`define STAT_SPARE_LO 4

// Interrupt event fields
`define IRQ_FOREGROUND_CAL_DONE 0
`define IRQ_SWAP 1

// Control reset value: pin trigger source
`define CTRL_RESET 8'h02

// Timing counts in cycles
`define FG_CAL_CYCLES 16'h0400
`define BG_CAL_CYCLES 16'h0800

// Factory trim defaults (arbitrary neutral values)
`define TRIM_OFFSET_DEF 16'h0080
`define TRIM_GAIN_DEF 16'h0100
`define TRIM_TIMING_DEF 16'h0040
`define TRIM_TERM_DEF 16'h0020

`endif

// [cal_seq_pkg.sv]
package cal_seq_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FG_CAL = 4'b0010,
    ST_BG_CAL = 4'b0100,
    ST_BG_SWAP = 4'b1000
  } cal_state_t;

  typedef enum logic [1:0] {
    CORE_A = 2'h0,
    CORE_B = 2'h1,
    CORE_C = 2'h2
  } core_id_t;
endpackage

// [cal_sequencer.sv]
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
`include "cal_seq_map.svh"

module cal_sequencer #(
  parameter int FG_CYCLES = `FG_CAL_CYCLES,
  parameter int BG_CYCLES = `BG_CAL_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cal_trigger_pin,
  input wire logic [11:0] sample_a,
  input wire logic [11:0] sample_b,
  input wire logic [11:0] sample_c,
  output logic [11:0] out_data_a,
  output logic [11:0] out_data_b,
  output logic [1:0] core_input_sel,
  output logic [2:0] bank_cal_active,
  output logic [5:0] bank_phase,
  output logic irq
);
  initial begin
    if (FG_CYCLES < 1 || FG_CYCLES > 65535 ||
        BG_CYCLES < 1 || BG_CYCLES > 65535) begin
      $error("cal_sequencer cycle counts must be 1 to 65535");
    end
  end

  cal_seq_pkg::cal_state_t state_r, state_nxt;
  cal_seq_pkg::core_id_t spare_r, spare_nxt;
  logic [7:0] ctrl_r;
  logic [1:0] irq_stat_r, irq_mask_r;
  logic foreground_cal_done_r;
  logic [15:0] cnt_r;
  logic pin_s1_r, pin_s2_r, pin_s3_r;
  logic sw_prev_r;
  logic boot_r;
  logic resp_r;
  logic [1:0] rd_phase_r;
  logic [5:0] phase_r;

  // Pin passes two flops before use; third stage is for edge detection
  // Reset level matches the idle pin, so no false rise after reset
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= cal_trigger_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Decode of bus access and control fields
  // Writes land on the edge where the master sees waitrequest low
  wire wr_hit = avs_write && !avs_waitrequest;
  // Read side effects land with the readdata capture, so a read-clear
  // never loses the value it is returning
  wire rd_hit = avs_read && !resp_r && rd_phase_r == 2'h1;
  wire wr_ctrl = wr_hit && avs_address == `REG_CTRL;
  wire wr_mask = wr_hit && avs_address == `REG_IRQ_MASK;
  wire trim_sel = avs_address[3:2] == 2'b01;
  wire wr_trim = wr_hit && trim_sel;
  wire bg_en = ctrl_r[`CTRL_BG_EN];
  wire src_sel = ctrl_r[`CTRL_SRC_SEL];
  wire sw_trig = ctrl_r[`CTRL_SW_TRIG];
  wire trig_level = src_sel ? pin_s2_r : sw_trig;
  wire trig_prev = src_sel ? pin_s3_r : sw_prev_r;
  wire trig_rise = trig_level && !trig_prev;
  // Background runs while enabled, soft source, trigger held
  wire bg_run = bg_en && !src_sel && sw_trig;
  wire cnt_zero = cnt_r == 16'h0000;
  wire swap_evt = state_r == cal_seq_pkg::ST_BG_SWAP;
  wire fg_end = state_r == cal_seq_pkg::ST_FG_CAL && cnt_zero;

  // Next-state: foreground wins at boot, trigger ignored while busy
  always_comb begin
    state_nxt = state_r;
    spare_nxt = spare_r;
    case (state_r)
      cal_seq_pkg::ST_IDLE: begin
        if (boot_r || (trig_rise && !bg_run)) begin
          state_nxt = cal_seq_pkg::ST_FG_CAL;
        end else if (bg_run) begin
          state_nxt = cal_seq_pkg::ST_BG_CAL;
        end
      end
      cal_seq_pkg::ST_FG_CAL: begin
        if (cnt_zero) begin
          state_nxt = cal_seq_pkg::ST_IDLE;
        end
      end
      cal_seq_pkg::ST_BG_CAL: begin
        if (!bg_run) begin
          state_nxt = cal_seq_pkg::ST_IDLE;
        end else if (cnt_zero) begin
          state_nxt = cal_seq_pkg::ST_BG_SWAP;
        end
      end
      cal_seq_pkg::ST_BG_SWAP: begin
        // Rotate C->A->B->C: freshly trimmed spare relieves next core
        case (spare_r)
          cal_seq_pkg::CORE_C: spare_nxt = cal_seq_pkg::CORE_A;
          cal_seq_pkg::CORE_A: spare_nxt = cal_seq_pkg::CORE_B;
          default: spare_nxt = cal_seq_pkg::CORE_C;
        endcase
        state_nxt = cal_seq_pkg::ST_BG_CAL;
      end
      default: state_nxt = cal_seq_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state and pass counter
  // Count reloads on every state change and on each swap
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= cal_seq_pkg::ST_IDLE;
      spare_r <= cal_seq_pkg::CORE_C;
      cnt_r <= 16'h0000;
      boot_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      spare_r <= spare_nxt;
      if (state_r != cal_seq_pkg::ST_FG_CAL) begin
        boot_r <= 1'b0;
      end
      if (state_nxt != state_r || swap_evt) begin
        cnt_r <= (state_nxt == cal_seq_pkg::ST_FG_CAL) ?
          16'(FG_CYCLES - 1) : 16'(BG_CYCLES - 1);
      end else if (!cnt_zero) begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  // Done flag: cleared at start, set when a foreground pass ends
  always_ff @(posedge clock) begin
    if (reset) begin
      foreground_cal_done_r <= 1'b0;
      sw_prev_r <= 1'b0;
    end else begin
      sw_prev_r <= sw_trig;
      if (fg_end) begin
        foreground_cal_done_r <= 1'b1;
      end else if (state_nxt == cal_seq_pkg::ST_FG_CAL &&
                   state_r != cal_seq_pkg::ST_FG_CAL) begin
        foreground_cal_done_r <= 1'b0;
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r <= `CTRL_RESET;
      irq_mask_r <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= avs_writedata[7:0];
      end
      if (wr_mask) begin
        irq_mask_r <= avs_writedata[1:0];
      end
    end
  end

  // Sticky events; a new event beats the read-clear of the same cycle
  wire [1:0] evt = {swap_evt, fg_end};
  wire rd_irq = rd_hit && avs_address == `REG_IRQ_STATUS;
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_stat_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (rd_irq ? 2'h0 : irq_stat_r) | evt;
      irq <= |(((rd_irq ? 2'h0 : irq_stat_r) | evt) & irq_mask_r);
    end
  end

  // One-hot core mask from a core code; anything but A or B is core C
  function automatic logic [2:0] core_bit(input cal_seq_pkg::core_id_t id);
    case (id)
      cal_seq_pkg::CORE_A: core_bit = 3'b001;
      cal_seq_pkg::CORE_B: core_bit = 3'b010;
      default: core_bit = 3'b100;
    endcase
  endfunction

  // Which cores sit out of service this cycle
  wire fg_busy = state_r == cal_seq_pkg::ST_FG_CAL;
  // Mute also covers reset and the boot edge, before the state shows it
  wire mute = fg_busy || boot_r;
  wire bg_live = state_r == cal_seq_pkg::ST_BG_CAL ||
    state_r == cal_seq_pkg::ST_BG_SWAP;
  wire [2:0] spare_bit = core_bit(spare_r);
  wire off_a = bg_live && spare_bit[0];
  wire off_b = bg_live && spare_bit[1];
  // Substitute: if A is spare, C takes its slot
  wire [11:0] src_a = off_a ? sample_c : sample_a;
  wire [11:0] src_b = off_b ? sample_c : sample_b;
  wire single = ctrl_r[`CTRL_SINGLE];
  // Bit 1 routes core A, bit 0 core B; 0 picks input A, 1 input B
  // Single-channel interleaves both cores onto the chosen input
  wire [1:0] in_sel = single ? {2{ctrl_r[`CTRL_IN_SEL]}} : 2'b01;
  wire [2:0] cal_act = fg_busy ? 3'b011 :
    (state_r == cal_seq_pkg::ST_BG_CAL) ? spare_bit : 3'b000;

  // Data path and core steering, all registered outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      out_data_a <= 12'h000;
      out_data_b <= 12'h000;
      core_input_sel <= 2'b01;
      bank_cal_active <= 3'b000;
      phase_r <= 6'b010101;
    end else begin
      out_data_a <= mute ? 12'h000 : src_a;
      out_data_b <= mute ? 12'h000 : src_b;
      core_input_sel <= in_sel;
      bank_cal_active <= cal_act;
      phase_r <= ~phase_r;
    end
  end
  assign bank_phase = phase_r;

  // Trim store: bus writes, registered read
  logic [15:0] trim_rd;
  trim_mem #(.DEPTH(4), .WIDTH(16)) u_trim (
    .clock(clock),
    .reset(reset),
    .wr_en(wr_trim),
    .wr_addr(avs_address[1:0]),
    .wr_data(avs_writedata[15:0]),
    .rd_addr(avs_address[1:0]),
    .rd_data(trim_rd)
  );

  // Status word; busy covers foreground and background passes
  // Offset-enable bits are kept for software but not acted on here
  wire [31:0] status_w = {26'h0, 2'(spare_r), off_b | fg_busy,
    off_a | fg_busy, state_r != cal_seq_pkg::ST_IDLE, foreground_cal_done_r};

  // Two-cycle read for every register so trim memory latency fits
  always_ff @(posedge clock) begin
    if (reset) begin
      resp_r <= 1'b0;
      rd_phase_r <= 2'h0;
    end else if (resp_r) begin
      resp_r <= 1'b0;
      rd_phase_r <= 2'h0;
    end else if (avs_write) begin
      resp_r <= 1'b1;
    end else if (avs_read) begin
      rd_phase_r <= rd_phase_r + 2'h1;
      resp_r <= rd_phase_r == 2'h1;
    end
  end

  // Waitrequest is low only in the answering cycle
  // Writes answer one edge after the request is seen, reads two
  always_ff @(posedge clock) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_write && !resp_r && !avs_waitrequest) ||
        (avs_write && avs_waitrequest && !resp_r) ||
        (avs_read && rd_phase_r == 2'h1 && !resp_r));
      if (avs_read && rd_phase_r == 2'h1) begin
        case (avs_address)
          `REG_CTRL: avs_readdata <= {24'h0, ctrl_r};
          `REG_STATUS: avs_readdata <= status_w;
          `REG_IRQ_STATUS: avs_readdata <= {30'h0, irq_stat_r};
          `REG_IRQ_MASK: avs_readdata <= {30'h0, irq_mask_r};
          default: avs_readdata <= trim_sel ? {16'h0, trim_rd} : 32'h0;
        endcase
      end
    end
  end
endmodule

// [cal_sequencer_props.sv]
`timescale 1ns/100ps
// Bus answer, bank phase and muting checks at the block's ports
module cal_sequencer_props #(
  parameter int FG_CYCLES = 8,
  parameter int BG_CYCLES = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cal_trigger_pin,
  input wire logic [11:0] sample_a,
  input wire logic [11:0] sample_b,
  input wire logic [11:0] sample_c,
  input wire logic [11:0] out_data_a,
  input wire logic [11:0] out_data_b,
  input wire logic [1:0] core_input_sel,
  input wire logic [2:0] bank_cal_active,
  input wire logic [5:0] bank_phase,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire req = avs_read | avs_write;
  // A held request gets exactly one answering cycle
  sequence s_req; $rose(req); endsequence
  sequence s_ans; ##[1:4] !avs_waitrequest; endsequence
  sequence s_mute; (out_data_a == 12'h000 && out_data_b == 12'h000) [*4];
  endsequence
  a_bus_answer: assert property (s_req |-> s_ans)
    else $error("bus request not answered in time");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held more than one cycle");
  a_answer_req: assert property (!avs_waitrequest |-> req)
    else $error("answer without a request");
  // Banks of one core sit on opposite phases and swap every cycle
  a_phase_pair: assert property (
    (bank_phase[0] ^ bank_phase[1]) && (bank_phase[2] ^ bank_phase[3])
    && (bank_phase[4] ^ bank_phase[5]))
    else $error("banks of a core in phase");
  a_phase_flip: assert property (
    !$past(reset) |-> bank_phase == ~$past(bank_phase))
    else $error("bank phase did not toggle");
  // Calibration after reset keeps both outputs at mid-code
  a_fg_mute: assert property ($fell(reset) |-> s_mute)
    else $error("output not muted after reset");
  // Cores under foreground calibration never reach the outputs
  a_cal_mute: assert property (bank_cal_active == 3'b011 |->
    out_data_a == 12'h000 && out_data_b == 12'h000)
    else $error("output not muted during calibration");
  // Each output carries its own core, core C, or mid-code
  a_out_a_src: assert property (out_data_a == 12'h000
    || out_data_a == $past(sample_a) || out_data_a == $past(sample_c))
    else $error("output a from an unexpected source");
  a_out_b_src: assert property (out_data_b == 12'h000
    || out_data_b == $past(sample_b) || out_data_b == $past(sample_c))
    else $error("output b from an unexpected source");
  // Interrupt only drops after a bus access cleared or masked it
  a_irq_clear: assert property (
    $fell(irq) |-> $past(req) || $past(req, 2) || $past(req, 3))
    else $error("interrupt dropped without an access");
endmodule

bind cal_sequencer cal_sequencer_props #(
  .FG_CYCLES(FG_CYCLES), .BG_CYCLES(BG_CYCLES)
) u_props (
  .clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .cal_trigger_pin, .sample_a, .sample_b,
  .sample_c, .out_data_a, .out_data_b, .core_input_sel, .bank_cal_active,
  .bank_phase, .irq
);

// [host_side_model.sv]
`timescale 1ns/100ps
// Host side: calibration trigger pin and the cores' sample streams
module host_side_model (
  input wire logic clock,
  input wire logic fire,
  output logic cal_trigger_pin,
  output logic [11:0] sample_a,
  output logic [11:0] sample_b,
  output logic [11:0] sample_c
);
  int hold;
  initial begin
    hold = 0;
    cal_trigger_pin = 1'b0;
    sample_a = 12'h001;
    sample_b = 12'h001;
    sample_c = 12'h001;
  end
  // Pin held high past the sync flops so one clean rise is seen
  always @(posedge clock) begin
    hold <= fire ? 6 : (hold > 0 ? hold - 1 : 0);
    cal_trigger_pin <= fire || hold > 1;
  end
  // Never zero, so a muted output cannot pass for data
  always @(posedge clock) begin
    sample_a <= 12'($urandom) | 12'h001;
    sample_b <= 12'($urandom) | 12'h001;
    sample_c <= 12'($urandom) | 12'h001;
  end
endmodule

// [trim_mem.sv]
`timescale 1ns/100ps
`include "cal_seq_map.svh"

// Trim store, loaded with factory values at reset, registered read data
module trim_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH != 4 || WIDTH < 16) begin
      $error("trim_mem needs DEPTH 4 and WIDTH at least 16");
    end
  end

  // Factory defaults for each trim slot
  function automatic logic [WIDTH-1:0] trim_default(input int idx);
    case (idx)
      0: trim_default = WIDTH'(`TRIM_OFFSET_DEF);
      1: trim_default = WIDTH'(`TRIM_GAIN_DEF);
      2: trim_default = WIDTH'(`TRIM_TIMING_DEF);
      default: trim_default = WIDTH'(`TRIM_TERM_DEF);
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : slot
      // Reset reloads factory value; software may overwrite
      always_ff @(posedge clock) begin
        if (reset) begin
          mem_r[g] <= trim_default(g);
        end else if (wr_en && wr_addr == 2'(g)) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule
